/* File: shared/hwc_params.svh */
// Constants for the hardware-mode pin configuration decoder
`ifndef HWC_PARAMS_SVH
`define HWC_PARAMS_SVH

`define HWC_CLK_PERIOD_NS    40
`define HWC_RST_LOW_MIN_NS   100
`define HWC_RST_LOW_CYC      ((`HWC_RST_LOW_MIN_NS + `HWC_CLK_PERIOD_NS - 1) / `HWC_CLK_PERIOD_NS)

`define HWC_OFS_CH1          4'h0
`define HWC_OFS_CH2          4'h4
`define HWC_OFS_GLOBAL       4'h8
`define HWC_OFS_STATUS       4'hC

`define HWC_F_PAT            0
`define HWC_F_RPD            2
`define HWC_F_TERM           3
`define HWC_F_MON            4
`define HWC_F_PULS           5
`define HWC_CH_W             6
`define HWC_G_JA             0

`define HWC_S_MODE           0
`define HWC_S_RST            2
`define HWC_S_HIZ            3
`define HWC_S_PINS           16

`define HWC_PIN_JA           12
`define HWC_PIN_MODE         14
`define HWC_PIN_HIZ          16
`define HWC_PIN_RSTN         17
`define HWC_PIN_W            18

`define HWC_CH_RST           6'h00
`define HWC_JA_RST           2'h0
`define HWC_JA_FIFO_NONE     8'h00
`define HWC_JA_FIFO_SHALLOW  8'h40
`define HWC_JA_FIFO_DEEP     8'h80

`endif

/* File: shared/hwc_pkg.sv */
// Types for the hardware-mode pin configuration decoder
`default_nettype none
package hwc_pkg;
    typedef enum logic [1:0] {
        PAT_NORMAL   = 2'h0,
        PAT_ALL_ONES = 2'h1,
        PAT_PRBS     = 2'h2,
        PAT_TX_OFF   = 2'h3
    } tx_pattern_e;

    typedef enum logic [1:0] {
        JA_OFF       = 2'h0,
        JA_RX_WIDE   = 2'h1,
        JA_RX_NARROW = 2'h2,
        JA_TX_NARROW = 2'h3
    } jitter_atten_e;

    typedef enum logic [1:0] {
        MODE_HW        = 2'h0,
        MODE_SW_SERIAL = 2'h1,
        MODE_SW_PAR_A  = 2'h2,
        MODE_SW_PAR_B  = 2'h3
    } ctrl_mode_e;
endpackage : hwc_pkg
`default_nettype wire

/* File: design/hw_mode_pin_config_decode.sv */
// Static control pin decoder with APB software configuration registers
// Functional notes
// - Per-channel pattern select: normal, all ones, PRBS, transmitter off.
// - Shared jitter select: off, rx wide 64, rx narrow 128, tx narrow 128.
// - Receiver power-down pin: 0 normal operation, 1 receiver powered down.
// - Impedance select: 0 internal matching, 1 external matching.
// - Monitor gain select: low gives 0 dB, high gives 26 dB.
// - Pulse select sets transmit template and 75 or 120 ohm termination.
// - Reset pin low longer than 100 ns puts device into reset state.
// - Driver high-impedance pin low enables drivers, high floats all of them.
// - High-impedance pin touches only the drivers, nothing else internally.
// - Control-mode pins 00 select hardware mode; pin settings other than reset and high-impedance apply only then.
`include "hwc_params.svh"
`default_nettype none
module hw_mode_pin_config_decode #(
    parameter int ADDR_W = 12
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output var  logic [31:0]             prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    input  wire logic                    hw_reset_n,
    input  wire logic                    tx_driver_hiz,
    input  wire logic                    ctrl_if_sel_hi,
    input  wire logic                    ctrl_if_sel_lo,
    input  wire logic                    jitter_atten_sel_hi,
    input  wire logic                    jitter_atten_sel_lo,
    input  wire logic                    tx_pattern_sel_ch1_hi,
    input  wire logic                    tx_pattern_sel_ch1_lo,
    input  wire logic                    tx_pattern_sel_ch2_hi,
    input  wire logic                    tx_pattern_sel_ch2_lo,
    input  wire logic                    rx_powerdown_ch1,
    input  wire logic                    rx_powerdown_ch2,
    input  wire logic                    impedance_match_sel_ch1,
    input  wire logic                    impedance_match_sel_ch2,
    input  wire logic                    monitor_gain_sel_ch1,
    input  wire logic                    monitor_gain_sel_ch2,
    input  wire logic                    pulse_template_sel_ch1,
    input  wire logic                    pulse_template_sel_ch2,
    output var  hwc_pkg::ctrl_mode_e     ctrl_mode,
    output var  logic                    hw_mode,
    output var  logic                    device_in_reset,
    output var  hwc_pkg::tx_pattern_e    tx_pattern [2],
    output var  logic [1:0]              tx_driver_en,
    output var  logic [1:0]              rx_powerdown,
    output var  logic [1:0]              term_external,
    output var  logic [1:0]              monitor_gain_26db,
    output var  logic [1:0]              pulse_120_ohm,
    output var  hwc_pkg::jitter_atten_e  ja_mode,
    output var  logic                    ja_enable,
    output var  logic                    ja_in_tx,
    output var  logic                    ja_narrow_bw,
    output var  logic [7:0]              ja_fifo_depth
);
    import hwc_pkg::*;
    localparam int          PIN_W   = `HWC_PIN_W;
    localparam int          CH_W    = `HWC_CH_W;
    localparam int          RST_INT = `HWC_RST_LOW_CYC;
    localparam logic [2:0]  RST_CYC = 3'(RST_INT);
    // Reset pin flops start at its idle level so a release never feeds the filter
    localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(1) << `HWC_PIN_RSTN;

    if (ADDR_W < 4 || ADDR_W > 32 || RST_INT < 1 || RST_INT > 7) begin : g_bad_cfg
        $error("Address width or reset filter count out of range");
    end

    // Pin synchroniser; every static pin is asynchronous to pclk
    logic [PIN_W-1:0]   pin_raw;
    logic [PIN_W-1:0]   pin_meta;
    logic [PIN_W-1:0]   pin_sync;
    logic [PIN_W-1:0]   next_pin_meta;
    logic [PIN_W-1:0]   next_pin_sync;
    assign pin_raw = {hw_reset_n, tx_driver_hiz, ctrl_if_sel_hi, ctrl_if_sel_lo,
                      jitter_atten_sel_hi, jitter_atten_sel_lo, pulse_template_sel_ch2,
                      monitor_gain_sel_ch2, impedance_match_sel_ch2, rx_powerdown_ch2,
                      tx_pattern_sel_ch2_hi, tx_pattern_sel_ch2_lo, pulse_template_sel_ch1,
                      monitor_gain_sel_ch1, impedance_match_sel_ch1, rx_powerdown_ch1,
                      tx_pattern_sel_ch1_hi, tx_pattern_sel_ch1_lo};
    always_comb begin
        next_pin_meta = clk_en ? pin_raw : pin_meta;
        next_pin_sync = clk_en ? pin_meta : pin_sync;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    wire [1:0]             pin_mode = pin_sync[`HWC_PIN_MODE +: 2];
    wire [1:0]             pin_ja   = pin_sync[`HWC_PIN_JA +: 2];
    wire                   pin_hiz  = pin_sync[`HWC_PIN_HIZ];
    wire                   pin_rstn = pin_sync[`HWC_PIN_RSTN];
    wire [CH_W-1:0]        pin_ch1  = pin_sync[0 +: CH_W];
    wire [CH_W-1:0]        pin_ch2  = pin_sync[CH_W +: CH_W];
    wire                   hw_sel   = (ctrl_mode_e'(pin_mode) == MODE_HW);

    // Reset pin filter; glitches up to the minimum width are ignored
    logic [2:0]  reset_cnt;
    logic [2:0]  next_reset_cnt;
    logic        next_device_in_reset;
    always_comb begin
        next_reset_cnt       = reset_cnt;
        next_device_in_reset = device_in_reset;
        if (clk_en) begin
            if (pin_rstn) begin
                next_reset_cnt       = 3'h0;
                next_device_in_reset = 1'b0;
            end else begin
                if (reset_cnt != RST_CYC) begin
                    next_reset_cnt = reset_cnt + 3'h1;
                end
                next_device_in_reset = (reset_cnt >= RST_CYC - 3'h1);
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cnt       <= 3'h0;
            device_in_reset <= 1'b0;
        end else begin
            reset_cnt       <= next_reset_cnt;
            device_in_reset <= next_device_in_reset;
        end
    end

    // APB slave, one wait-free access phase; pready is registered
    logic [1:0][CH_W-1:0]  ch_reg;
    logic [1:0][CH_W-1:0]  next_ch_reg;
    logic [1:0]            ja_reg;
    logic [1:0]            next_ja_reg;
    logic [31:0]           rd_word;
    logic [31:0]           next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;
    wire                   addr_ok = (paddr[ADDR_W-1:4] == '0) && (paddr[1:0] == 2'h0);
    wire                   wr_fire = psel && penable && pready && pwrite && addr_ok;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr[3:0])
            `HWC_OFS_CH1:    rd_word[CH_W-1:0] = ch_reg[0];
            `HWC_OFS_CH2:    rd_word[CH_W-1:0] = ch_reg[1];
            `HWC_OFS_GLOBAL: rd_word[`HWC_G_JA +: 2] = ja_reg;
            `HWC_OFS_STATUS: begin
                rd_word[`HWC_S_MODE +: 2] = pin_mode;
                rd_word[`HWC_S_RST]       = device_in_reset;
                rd_word[`HWC_S_HIZ]       = pin_hiz;
                rd_word[`HWC_S_PINS +: 14] = pin_sync[13:0];
            end
            default:         rd_word = 32'h0000_0000;
        endcase
    end
    always_comb begin
        next_pready  = pready;
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (clk_en) begin
            next_pready = 1'b0;
            if (psel && !penable) begin
                next_pready  = 1'b1;
                next_pslverr = !addr_ok;
                next_prdata  = (addr_ok && !pwrite) ? rd_word : 32'h0000_0000;
            end
        end
    end
    always_comb begin
        next_ch_reg = ch_reg;
        next_ja_reg = ja_reg;
        if (clk_en) begin
            if (device_in_reset) begin
                next_ch_reg = {`HWC_CH_RST, `HWC_CH_RST};
                next_ja_reg = `HWC_JA_RST;
            end else if (wr_fire) begin
                unique case (paddr[3:0])
                    `HWC_OFS_CH1:    next_ch_reg[0] = pwdata[CH_W-1:0];
                    `HWC_OFS_CH2:    next_ch_reg[1] = pwdata[CH_W-1:0];
                    `HWC_OFS_GLOBAL: next_ja_reg    = pwdata[`HWC_G_JA +: 2];
                    default:         next_ja_reg    = ja_reg;
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ch_reg  <= {`HWC_CH_RST, `HWC_CH_RST};
            ja_reg  <= `HWC_JA_RST;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
            ch_reg  <= next_ch_reg;
            ja_reg  <= next_ja_reg;
        end
    end
    // Source select per channel: pins in hardware mode, registers otherwise
    wire [1:0][CH_W-1:0]   cfg_sel;
    wire [1:0][CH_W-1:0]   pin_chs = {pin_ch2, pin_ch1};
    wire [1:0]             ja_sel  = hw_sel ? pin_ja : ja_reg;
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        assign cfg_sel[ch] = hw_sel ? pin_chs[ch] : ch_reg[ch];
    end
    // Decoded outputs; drivers float in reset so a held line stays quiet
    tx_pattern_e    next_tx_pattern [2];
    logic [1:0]     next_tx_driver_en;
    logic [1:0]     next_rx_powerdown;
    logic [1:0]     next_term_external;
    logic [1:0]     next_monitor_gain_26db;
    logic [1:0]     next_pulse_120_ohm;
    jitter_atten_e  next_ja_mode;
    jitter_atten_e  ja_dec;
    logic [7:0]     next_ja_fifo_depth;
    always_comb begin
        ja_dec = jitter_atten_e'(ja_sel);
        for (int ch = 0; ch < 2; ch++) begin
            next_tx_pattern[ch]        = device_in_reset ? PAT_NORMAL
                                       : tx_pattern_e'(cfg_sel[ch][`HWC_F_PAT +: 2]);
            next_rx_powerdown[ch]      = !device_in_reset && cfg_sel[ch][`HWC_F_RPD];
            next_term_external[ch]     = !device_in_reset && cfg_sel[ch][`HWC_F_TERM];
            next_monitor_gain_26db[ch] = !device_in_reset && cfg_sel[ch][`HWC_F_MON];
            next_pulse_120_ohm[ch]     = !device_in_reset && cfg_sel[ch][`HWC_F_PULS];
            next_tx_driver_en[ch]      = !device_in_reset && !pin_hiz;
        end
        next_ja_mode = device_in_reset ? JA_OFF : ja_dec;
        unique case (next_ja_mode)
            JA_OFF:     next_ja_fifo_depth = `HWC_JA_FIFO_NONE;
            JA_RX_WIDE: next_ja_fifo_depth = `HWC_JA_FIFO_SHALLOW;
            default:    next_ja_fifo_depth = `HWC_JA_FIFO_DEEP;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_mode         <= MODE_HW;
            hw_mode           <= 1'b1;
            tx_pattern[0]     <= PAT_NORMAL;
            tx_pattern[1]     <= PAT_NORMAL;
            tx_driver_en      <= 2'h0;
            rx_powerdown      <= 2'h0;
            term_external     <= 2'h0;
            monitor_gain_26db <= 2'h0;
            pulse_120_ohm     <= 2'h0;
            ja_mode           <= JA_OFF;
            ja_enable         <= 1'b0;
            ja_in_tx          <= 1'b0;
            ja_narrow_bw      <= 1'b0;
            ja_fifo_depth     <= `HWC_JA_FIFO_NONE;
        end else if (clk_en) begin
            ctrl_mode         <= ctrl_mode_e'(pin_mode);
            hw_mode           <= hw_sel;
            tx_pattern[0]     <= next_tx_pattern[0];
            tx_pattern[1]     <= next_tx_pattern[1];
            tx_driver_en      <= next_tx_driver_en;
            rx_powerdown      <= next_rx_powerdown;
            term_external     <= next_term_external;
            monitor_gain_26db <= next_monitor_gain_26db;
            pulse_120_ohm     <= next_pulse_120_ohm;
            ja_mode           <= next_ja_mode;
            ja_enable         <= (next_ja_mode != JA_OFF);
            ja_in_tx          <= (next_ja_mode == JA_TX_NARROW);
            ja_narrow_bw      <= (next_ja_mode == JA_RX_NARROW) || (next_ja_mode == JA_TX_NARROW);
            ja_fifo_depth     <= next_ja_fifo_depth;
        end
    end

    // Checks; the clock must keep running for the reset filter to act
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tx_pattern;
        (clk_en && hw_sel && !device_in_reset)
            |=> tx_pattern[1] == tx_pattern_e'($past(pin_ch2[1:0]));
    endproperty
    a_tx_pattern: assert property (p_tx_pattern) else $error("pattern decode wrong");
    property p_ja_fifo;
        ja_enable |-> (ja_narrow_bw ? ja_fifo_depth == `HWC_JA_FIFO_DEEP
                                    : ja_fifo_depth == `HWC_JA_FIFO_SHALLOW && !ja_in_tx);
    endproperty
    a_ja_fifo: assert property (p_ja_fifo) else $error("jitter FIFO depth wrong");
    property p_ja_pins;
        (clk_en && hw_sel && !device_in_reset)
            |=> ja_mode == jitter_atten_e'($past(pin_ja)) && ja_enable == ($past(pin_ja) != 2'h0);
    endproperty
    a_ja_pins: assert property (p_ja_pins) else $error("jitter select wrong");
    property p_rx_pd;
        (clk_en && hw_sel && !device_in_reset) |=> rx_powerdown[0] == $past(pin_ch1[2]);
    endproperty
    a_rx_pd: assert property (p_rx_pd) else $error("receiver power-down wrong");
    property p_term;
        (clk_en && hw_sel && !device_in_reset) |=> term_external[1] == $past(pin_ch2[3]);
    endproperty
    a_term: assert property (p_term) else $error("impedance select wrong");
    property p_mon;
        (clk_en && hw_sel && !device_in_reset) |=> monitor_gain_26db[0] == $past(pin_ch1[4]);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor gain wrong");
    property p_puls;
        (clk_en && hw_sel && !device_in_reset) |=> pulse_120_ohm[1] == $past(pin_ch2[5]);
    endproperty
    a_puls: assert property (p_puls) else $error("pulse template wrong");
    property p_rst_enter;
        (clk_en && !pin_rstn && reset_cnt == RST_CYC - 3'h1) |=> device_in_reset;
    endproperty
    a_rst_enter: assert property (p_rst_enter) else $error("reset not entered");
    property p_rst_filter;
        (clk_en && pin_rstn) |=> !device_in_reset ##0 reset_cnt == 3'h0;
    endproperty
    a_rst_filter: assert property (p_rst_filter) else $error("reset filter wrong");
    property p_hiz;
        (clk_en && !device_in_reset) |=> tx_driver_en == {2{!$past(pin_hiz)}};
    endproperty
    a_hiz: assert property (p_hiz) else $error("driver enable wrong");
    property p_hiz_only;
        (clk_en && hw_sel && !device_in_reset && pin_hiz)
            |=> tx_driver_en == 2'h0 && rx_powerdown[1] == $past(pin_ch2[2]);
    endproperty
    a_hiz_only: assert property (p_hiz_only) else $error("high-impedance leaked");
    property p_mode;
        clk_en |=> hw_mode == ($past(pin_mode) == 2'h0);
    endproperty
    a_mode: assert property (p_mode) else $error("mode flag wrong");
    property p_sw;
        (clk_en && !hw_sel && !device_in_reset) |=> rx_powerdown[1] == $past(ch_reg[1][2]);
    endproperty
    a_sw: assert property (p_sw) else $error("software setting ignored");
endmodule : hw_mode_pin_config_decode
`default_nettype wire

/* File: verification/strap_pins.sv */
// Board strap model that holds the static selection pin levels
`default_nettype none
module strap_pins (
    input  wire logic [17:0] strap,
    output var  logic [17:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Straps are plain levels; the bench moves them only just after a clock edge
    always_comb begin
        pins = strap;
    end
endmodule : strap_pins
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the hardware-mode pin configuration decoder
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import hwc_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          clk_en = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata, rd, wd;
    logic          pready, pslverr, err;
    logic [17:0]   strap = 18'h20000;
    logic [17:0]   pins, v;
    tx_pattern_e   tx_pattern [2];
    ctrl_mode_e    ctrl_mode;
    jitter_atten_e ja_mode;
    logic          hw_mode, device_in_reset, ja_enable, ja_in_tx, ja_narrow_bw;
    logic [1:0]    tx_driver_en, rx_powerdown, term_external, monitor_gain_26db, pulse_120_ohm;
    logic [7:0]    ja_fifo_depth;
    logic [5:0]    r1, r2;
    logic [1:0]    rja;
    int            n_mismatch = 0;
    int            samples_checked = 0;
    int            seed = 83184;

    // Clock keeps running through every reset
    initial forever #20 pclk = ~pclk;

    strap_pins u_straps (.strap(strap), .pins(pins));

    hw_mode_pin_config_decode u_dut (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hw_reset_n(pins[17]), .tx_driver_hiz(pins[16]),
        .ctrl_if_sel_hi(pins[15]), .ctrl_if_sel_lo(pins[14]),
        .jitter_atten_sel_hi(pins[13]), .jitter_atten_sel_lo(pins[12]),
        .tx_pattern_sel_ch1_hi(pins[1]), .tx_pattern_sel_ch1_lo(pins[0]),
        .tx_pattern_sel_ch2_hi(pins[7]), .tx_pattern_sel_ch2_lo(pins[6]),
        .rx_powerdown_ch1(pins[2]), .rx_powerdown_ch2(pins[8]),
        .impedance_match_sel_ch1(pins[3]), .impedance_match_sel_ch2(pins[9]),
        .monitor_gain_sel_ch1(pins[4]), .monitor_gain_sel_ch2(pins[10]),
        .pulse_template_sel_ch1(pins[5]), .pulse_template_sel_ch2(pins[11]),
        .ctrl_mode, .hw_mode, .device_in_reset, .tx_pattern, .tx_driver_en, .rx_powerdown,
        .term_external, .monitor_gain_26db, .pulse_120_ohm, .ja_mode, .ja_enable,
        .ja_in_tx, .ja_narrow_bw, .ja_fifo_depth
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // Depth, narrow, in transmit, enable, mode
    function automatic logic [13:0] ja_exp(input logic [1:0] ja);
        logic [7:0] d;
        d = (ja == 2'h0) ? 8'h00 : (ja == 2'h1) ? 8'h40 : 8'h80;
        return {d, ja[1], ja == 2'h3, ja != 2'h0, ja};
    endfunction : ja_exp

    // One APB transfer; no wait count is assumed, pready is polled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        check(32'(pready), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Pins pass two sync flops and one output flop, so four edges is enough
    task automatic set_pins(input logic [17:0] p);
        @(posedge pclk);
        strap <= p;
        repeat (4) @(posedge pclk);
        #1;
    endtask : set_pins

    task automatic check_out(input logic [5:0] c1, input logic [5:0] c2,
                             input logic [1:0] ja, input logic hiz, input logic [1:0] mode);
        logic [5:0] e;
        for (int c = 0; c < 2; c++) begin
            e = (c == 0) ? c1 : c2;
            check(32'(tx_pattern[c]), 32'(e[1:0]));
            check(32'(rx_powerdown[c]), 32'(e[2]));
            check(32'(term_external[c]), 32'(e[3]));
            check(32'(monitor_gain_26db[c]), 32'(e[4]));
            check(32'(pulse_120_ohm[c]), 32'(e[5]));
        end
        check(32'({ja_fifo_depth, ja_narrow_bw, ja_in_tx, ja_enable, ja_mode}),
              32'(ja_exp(ja)));
        check(32'(tx_driver_en), 32'({2{~hiz}}));
        check(32'(ctrl_mode), 32'(mode));
        check(32'(hw_mode), 32'(mode == 2'h0));
    endtask : check_out

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        set_pins(18'h20000);
        check_out(6'h00, 6'h00, 2'h0, 1'b0, 2'h0);
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            check(32'(err), 32'h0);
            check(rd, 32'h0);
        end
        // Hardware mode: every code first, then random straps
        for (int i = 0; i < 40; i++) begin
            v = 18'($random(seed));
            v[17] = 1'b1;
            v[15:14] = 2'h0;
            v[16] = (i % 5 == 2);
            if (i < 4) begin
                v[1:0] = 2'(i);
                v[7:6] = 2'(3 - i);
                v[13:12] = 2'(i);
            end
            set_pins(v);
            check_out(v[5:0], v[11:6], v[13:12], v[16], 2'h0);
        end
        // Enable low freezes every flop, so new straps wait until it returns
        wd = $random(seed);
        wd[17:14] = 4'h8;
        @(posedge pclk);
        clk_en <= 1'b0;
        set_pins(wd[17:0]);
        check_out(v[5:0], v[11:6], v[13:12], v[16], 2'h0);
        @(posedge pclk);
        clk_en <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        check_out(wd[5:0], wd[11:6], wd[13:12], wd[16], 2'h0);
        // Software modes: registers rule, straps other than mode, high-impedance and reset are ignored
        for (int m = 1; m < 4; m++) begin
            r1 = 6'($random(seed)) | 6'h01;
            r2 = 6'($random(seed));
            rja = 2'($random(seed));
            wd = $random(seed);
            apb(1'b1, 12'h000, {wd[31:6], r1});
            apb(1'b1, 12'h004, {wd[31:6], r2});
            apb(1'b1, 12'h008, {wd[31:2], rja});
            apb(1'b0, 12'h000, 32'h0);
            check(rd, 32'(r1));
            apb(1'b0, 12'h004, 32'h0);
            check(rd, 32'(r2));
            apb(1'b0, 12'h008, 32'h0);
            check(rd, 32'(rja));
            v = 18'($random(seed));
            v[17] = 1'b1;
            v[15:14] = 2'(m);
            set_pins(v);
            check_out(r1, r2, rja, v[16], v[15:14]);
            apb(1'b0, 12'h00C, 32'h0);
            check(rd, {2'h0, v[13:0], 12'h0, v[16], 1'b0, v[15:14]});
        end
        apb(1'b0, 12'h010, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, 12'h006, 32'hFFFFFFFF);
        check(32'(err), 32'h1);
        // A short low pulse on the reset pin is filtered out
        @(posedge pclk);
        strap[17] <= 1'b0;
        repeat (2) @(posedge pclk);
        strap[17] <= 1'b1;
        repeat (6) begin
            @(posedge pclk);
            #1;
            check(32'(device_in_reset), 32'h0);
        end
        @(posedge pclk);
        strap[17] <= 1'b0;
        repeat (8) @(posedge pclk);
        #1;
        check(32'(device_in_reset), 32'h1);
        check(32'(tx_driver_en), 32'h0);
        @(posedge pclk);
        strap[17] <= 1'b1;
        repeat (5) @(posedge pclk);
        #1;
        check(32'(device_in_reset), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        // Back to hardware mode
        v = 18'($random(seed));
        v[17:14] = 4'h8;
        set_pins(v);
        check_out(v[5:0], v[11:6], v[13:12], 1'b0, 2'h0);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
